/* hdl/fbd_ctrl.sv */
// host-side controller driving a parallel flash through its pins, apb slave
//
// Chosen here: the register offsets and the APB slave port.
`default_nettype none
module fbd_ctrl import fbd_pkg::*; (
    input  wire logic        i_mclk,
    input  wire logic        i_arst_n,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    output logic      [21:0] o_addr,
    output logic             o_ce_n,
    output logic             o_oe_n,
    output logic             o_we_n,
    output logic             o_reset_n,
    output logic             o_byte_n,
    input  wire logic [15:0] i_dq_in,
    output logic      [15:0] o_dq_out,
    output logic      [15:0] o_dq_oe,
    output logic             o_fast_prog_hv,
    output logic             o_protect_n_out,
    output logic             o_protect_n_oe
);
    typedef struct packed {
        fbd_state_t  st;
        logic [7:0]  cnt;
        logic [22:0] addr;
        logic [15:0] wdata;
        logic [15:0] rdata;
        logic [1:0]  op;
        logic        byte_mode;
        logic        accel;
        logic        protect;
        logic        hold_sel;
        logic        buf_mode;
        logic        done;
        logic        err;
        logic        page_hit;
        logic        page_valid;
        logic [18:0] last_page;
        logic [5:0]  buf_cnt;
        logic        ce_n;
        logic        oe_n;
        logic        we_n;
        logic        rst_n;
        logic        dq_drv;
        logic [15:0] dq_s1;
        logic [15:0] dq_s2;
    } fbd_regs_t;
    fbd_regs_t r;
    fbd_regs_t next_r;
    logic      wr_acc;
    logic      busy;

    // page number of an address; in-page bits differ by width
    function automatic logic [18:0] page_of(input logic [22:0] a,
                                            input logic        bm);
        return bm ? a[22:4] : a[21:3];
    endfunction : page_of
    function automatic logic [5:0] buf_limit(input logic bm);
        return bm ? FBD_BUF_BYTES : FBD_BUF_WORDS;
    endfunction : buf_limit

    ////////////////////////////////////////////////////////////////////////
    // apb slave: zero wait states, unmapped offsets answer with an error
    assign o_pready = 1'b1;
    assign wr_acc   = i_psel & i_penable & i_pwrite;
    assign busy     = (r.st != FBD_IDLE);

    always_comb begin
        o_prdata  = 32'h0000_0000;
        o_pslverr = 1'b0;
        case (i_paddr)
            FBD_CTRL_OFS: begin
                o_prdata[FBD_CTRL_OP +: 2] = r.op;
                o_prdata[FBD_CTRL_BYTE]    = r.byte_mode;
                o_prdata[FBD_CTRL_ACCEL]   = r.accel;
                o_prdata[FBD_CTRL_PROT]    = r.protect;
                o_prdata[FBD_CTRL_HOLD]    = r.hold_sel;
                o_prdata[FBD_CTRL_BUF]     = r.buf_mode;
            end
            FBD_ADDR_OFS:  o_prdata[22:0] = r.addr;
            FBD_WDATA_OFS: o_prdata[15:0] = r.wdata;
            FBD_RDATA_OFS: o_prdata[15:0] = r.rdata;
            FBD_STATUS_OFS: begin
                o_prdata[FBD_ST_BUSY]      = busy;
                o_prdata[FBD_ST_DONE]      = r.done;
                o_prdata[FBD_ST_ERR]       = r.err;
                o_prdata[FBD_ST_HIT]       = r.page_hit;
                o_prdata[FBD_ST_BCNT +: 6] = r.buf_cnt;
            end
            default: o_pslverr = i_psel & i_penable;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // next-state logic: register writes, then the pin sequencer
    always_comb begin
        next_r       = r;
        next_r.dq_s1 = i_dq_in;          // pins are asynchronous to i_mclk
        next_r.dq_s2 = r.dq_s1;
        // done and err flags clear on write-one (hit does not); a set below wins
        if (wr_acc && i_paddr == FBD_STATUS_OFS) begin
            if (i_pwdata[FBD_ST_DONE]) next_r.done = 1'b0;
            if (i_pwdata[FBD_ST_ERR])  next_r.err  = 1'b0;
        end
        // config is frozen while a pin cycle runs so widths cannot shift
        if (wr_acc && !busy) begin
            case (i_paddr)
                FBD_ADDR_OFS:  next_r.addr  = i_pwdata[22:0];
                FBD_WDATA_OFS: next_r.wdata = i_pwdata[15:0];
                FBD_CTRL_OFS: begin
                    next_r.op        = i_pwdata[FBD_CTRL_OP +: 2];
                    next_r.byte_mode = i_pwdata[FBD_CTRL_BYTE];
                    if (i_pwdata[FBD_CTRL_BYTE] != r.byte_mode) begin
                        next_r.buf_cnt = 6'h00;  // count is per width
                    end
                    next_r.accel     = i_pwdata[FBD_CTRL_ACCEL];
                    next_r.protect   = i_pwdata[FBD_CTRL_PROT];
                    next_r.hold_sel  = i_pwdata[FBD_CTRL_HOLD];
                    next_r.buf_mode  = i_pwdata[FBD_CTRL_BUF];
                end
                default: ;
            endcase
        end
        case (r.st)
            FBD_IDLE: begin
                if (!r.hold_sel) begin
                    next_r.ce_n       = 1'b1;  // select released: page lost
                    next_r.page_valid = 1'b0;
                end
                if (wr_acc && i_paddr == FBD_CTRL_OFS &&
                    i_pwdata[FBD_CTRL_START]) begin
                    if (next_r.op == FBD_OP_RESET) begin
                        next_r.ce_n       = 1'b1;
                        next_r.rst_n      = 1'b0;
                        next_r.page_valid = 1'b0;
                        next_r.buf_cnt    = 6'h00;
                        next_r.cnt        = 8'(FBD_RP_CYC - 1);
                        next_r.st         = FBD_RPULSE;
                    end else if (next_r.op == FBD_OP_READ) begin
                        if (next_r.accel) begin
                            next_r.err = 1'b1;     // no reads at high voltage
                        end else begin
                            // same page with select still low: short wait
                            next_r.page_hit = !r.ce_n && r.page_valid &&
                                (page_of(next_r.addr, next_r.byte_mode)
                                 == r.last_page);
                            next_r.cnt = next_r.page_hit ?
                                8'(FBD_PAGE_CYC + FBD_SYNC_CYC - 1) :
                                8'(FBD_ACC_CYC + FBD_SYNC_CYC - 1);
                            next_r.ce_n = 1'b0;
                            next_r.oe_n = 1'b0;
                            next_r.st   = FBD_RWAIT;
                        end
                    end else if (next_r.op == FBD_OP_WRITE) begin
                        if (next_r.buf_mode && next_r.buf_cnt >=
                            buf_limit(next_r.byte_mode)) begin
                            next_r.err = 1'b1;     // buffer already full
                        end else begin
                            next_r.buf_cnt = next_r.buf_mode ?
                                next_r.buf_cnt + 6'h01 : 6'h00;
                            next_r.ce_n       = 1'b0;
                            next_r.oe_n       = 1'b1;
                            next_r.dq_drv     = 1'b1;
                            next_r.page_valid = 1'b0;
                            next_r.st         = FBD_WSETUP;
                        end
                    end else begin
                        next_r.err = 1'b1;         // undefined op code
                    end
                end
            end
            FBD_WSETUP: begin
                next_r.we_n = 1'b0;
                next_r.cnt  = 8'(FBD_WP_CYC - 1);
                next_r.st   = FBD_WSTROBE;
            end
            FBD_WSTROBE: begin
                if (r.cnt == 8'h00) begin
                    next_r.we_n = 1'b1;     // rising strobe latches the cycle
                    next_r.st   = FBD_WHOLD;
                end else begin
                    next_r.cnt = r.cnt - 8'h01;
                end
            end
            FBD_WHOLD: begin
                // data held one cycle past the strobe for hold time
                next_r.ce_n   = 1'b1;
                next_r.dq_drv = 1'b0;
                next_r.done   = 1'b1;
                next_r.st     = FBD_IDLE;
            end
            FBD_RWAIT: begin
                if (r.cnt == 8'h00) begin
                    next_r.st = FBD_RSAMPLE;
                end else begin
                    next_r.cnt = r.cnt - 8'h01;
                end
            end
            FBD_RSAMPLE: begin
                // byte mode only has the low eight pins valid
                next_r.rdata = r.byte_mode ? {8'h00, r.dq_s2[7:0]}
                                           : r.dq_s2;
                next_r.oe_n       = 1'b1;
                next_r.ce_n       = !r.hold_sel;
                next_r.page_valid = r.hold_sel;
                next_r.last_page  = page_of(r.addr, r.byte_mode);
                next_r.done       = 1'b1;
                next_r.st         = FBD_IDLE;
            end
            FBD_RPULSE: begin
                if (r.cnt == 8'h00) begin
                    next_r.rst_n = 1'b1;
                    next_r.cnt   = 8'(FBD_RH_CYC - 1);
                    next_r.st    = FBD_RRECOV;
                end else begin
                    next_r.cnt = r.cnt - 8'h01;
                end
            end
            FBD_RRECOV: begin
                if (r.cnt == 8'h00) begin
                    next_r.done = 1'b1;
                    next_r.st   = FBD_IDLE;
                end else begin
                    next_r.cnt = r.cnt - 8'h01;
                end
            end
            default: next_r.st = FBD_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // state register; pins idle deselected with the bus released
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            r       <= '0;
            r.st    <= FBD_IDLE;
            r.cnt   <= FBD_RST_CNT;
            r.ce_n  <= 1'b1;
            r.oe_n  <= 1'b1;
            r.we_n  <= 1'b1;
            r.rst_n <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin drivers; in byte mode pins 8-14 float and pin 15 carries lsb
    assign o_addr    = r.byte_mode ? r.addr[22:1] : r.addr[21:0];
    assign o_ce_n    = r.ce_n;
    assign o_oe_n    = r.oe_n;
    assign o_we_n    = r.we_n;
    assign o_reset_n = r.rst_n;
    assign o_byte_n  = !r.byte_mode;
    assign o_dq_out  = r.byte_mode ? {r.addr[0], 7'h00, r.wdata[7:0]}
                                   : r.wdata;
    assign o_dq_oe   = r.byte_mode ?
                       {r.rst_n, 7'h00, {8{r.dq_drv}}} : {16{r.dq_drv}};
    // high voltage only while accel is armed and no read runs
    assign o_fast_prog_hv  = r.accel && r.oe_n;
    // open drain: release lets the pull-up read high
    assign o_protect_n_out = 1'b0;
    assign o_protect_n_oe  = r.protect;

    ////////////////////////////////////////////////////////////////////////
    // checks on the pin sequencing
    default clocking fbd_cb @(posedge i_mclk); endclocking
    default disable iff (!i_arst_n);

    read_levels_a: assert property (!o_oe_n |-> !o_ce_n && o_we_n && o_reset_n)
        else $error("read strobe with bad control levels");
    write_levels_a: assert property (!o_we_n |-> !o_ce_n && o_oe_n && o_reset_n)
        else $error("write strobe with bad control levels");
    no_contention_a: assert property (!o_oe_n |-> o_dq_oe[7:0] == 8'h00)
        else $error("host drives data while device outputs");
    byte_float_a: assert property (!o_byte_n |-> o_dq_oe[14:8] == 7'h00)
        else $error("upper data pins driven in byte mode");
    accel_read_a: assert property (o_fast_prog_hv |-> o_oe_n)
        else $error("high voltage applied during a read");
    buf_limit_a: assert property (r.buf_cnt <= buf_limit(r.byte_mode))
        else $error("buffered program exceeds its size");
    reset_pulse_a: assert property ($fell(o_reset_n) |-> (!o_reset_n)[*5])
        else $error("reset pulse too short");
    wr_pulse_a: assert property ($fell(o_we_n) |=> o_we_n ##1 o_ce_n)
        else $error("write strobe or release timing wrong");
    read_done_a: assert property ($fell(o_oe_n) && !$past(o_ce_n) |->
        ##[1:12] (o_oe_n && r.done))
        else $error("read did not complete in time");
    read_cov: cover property ($rose(o_oe_n) ##1 r.done);
    write_cov: cover property ($rose(o_we_n) ##2 r.done);
    page_cov: cover property (r.page_hit && $fell(o_oe_n));
    reset_cov: cover property ($rose(o_reset_n));
endmodule : fbd_ctrl
`default_nettype wire

/* shared/fbd_pkg.sv */
// constants, types and register map of the parallel flash bus controller
`default_nettype none
package fbd_pkg;
    // apb register byte offsets
    localparam logic [7:0] FBD_CTRL_OFS   = 8'h00;
    localparam logic [7:0] FBD_ADDR_OFS   = 8'h04;
    localparam logic [7:0] FBD_WDATA_OFS  = 8'h08;
    localparam logic [7:0] FBD_RDATA_OFS  = 8'h0C;
    localparam logic [7:0] FBD_STATUS_OFS = 8'h10;
    // control register fields
    localparam int FBD_CTRL_START = 0;
    localparam int FBD_CTRL_OP    = 1;   // two bits
    localparam int FBD_CTRL_BYTE  = 3;
    localparam int FBD_CTRL_ACCEL = 4;
    localparam int FBD_CTRL_PROT  = 5;
    localparam int FBD_CTRL_HOLD  = 6;
    localparam int FBD_CTRL_BUF   = 7;
    // status register fields
    localparam int FBD_ST_BUSY = 0;
    localparam int FBD_ST_DONE = 1;
    localparam int FBD_ST_ERR  = 2;
    localparam int FBD_ST_HIT  = 3;
    localparam int FBD_ST_BCNT = 8;      // six bits
    // operation codes
    localparam logic [1:0] FBD_OP_READ  = 2'h0;
    localparam logic [1:0] FBD_OP_WRITE = 2'h1;
    localparam logic [1:0] FBD_OP_RESET = 2'h2;
    // buffered program limits
    localparam logic [5:0] FBD_BUF_WORDS = 6'h10;
    localparam logic [5:0] FBD_BUF_BYTES = 6'h20;
    // timing in ns and derived cycle counts at the clock rate
    localparam int FBD_CLK_MHZ          = 10;
    localparam int FBD_ADDR_TO_DATA_NS  = 90;
    localparam int FBD_CS_ACCESS_NS     = 90;
    localparam int FBD_IN_PAGE_NS       = 25;
    localparam int FBD_WR_PULSE_NS      = 35;
    localparam int FBD_RST_PULSE_NS     = 500;
    localparam int FBD_RST_RECOVER_NS   = 200;
    localparam int FBD_SYNC_CYC         = 2;
    function automatic int fbd_cyc(input int ns);
        int c;
        c = (ns * FBD_CLK_MHZ + 999) / 1000;
        return (c < 1) ? 1 : c;
    endfunction : fbd_cyc
    localparam int FBD_ACC_CYC = (fbd_cyc(FBD_ADDR_TO_DATA_NS) >
        fbd_cyc(FBD_CS_ACCESS_NS)) ? fbd_cyc(FBD_ADDR_TO_DATA_NS)
                                   : fbd_cyc(FBD_CS_ACCESS_NS);
    localparam int FBD_PAGE_CYC = fbd_cyc(FBD_IN_PAGE_NS);
    localparam int FBD_WP_CYC   = fbd_cyc(FBD_WR_PULSE_NS);
    localparam int FBD_RP_CYC   = fbd_cyc(FBD_RST_PULSE_NS);
    localparam int FBD_RH_CYC   = fbd_cyc(FBD_RST_RECOVER_NS);
    localparam logic [7:0] FBD_RST_CNT = 8'h00;
    // controller states, one-hot
    typedef enum logic [7:0] {
        FBD_IDLE    = 8'h01,
        FBD_WSETUP  = 8'h02,
        FBD_WSTROBE = 8'h04,
        FBD_WHOLD   = 8'h08,
        FBD_RWAIT   = 8'h10,
        FBD_RSAMPLE = 8'h20,
        FBD_RPULSE  = 8'h40,
        FBD_RRECOV  = 8'h80
    } fbd_state_t;
endpackage : fbd_pkg
`default_nettype wire

/* dv/fbd_flash_model.sv */
// behavioural parallel flash device answering the controller's pins
`default_nettype none
module fbd_flash_model (
    input  wire logic [21:0] i_addr,
    input  wire logic        i_ce_n,
    input  wire logic        i_oe_n,
    input  wire logic        i_we_n,
    input  wire logic        i_reset_n,
    input  wire logic        i_byte_n,
    input  wire logic [15:0] i_dq,
    input  wire logic        i_fast_prog_hv,
    input  wire logic        i_protect_n,
    output logic      [15:0] o_dq,
    output logic      [15:0] o_dq_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [256];
    logic [15:0] word;
    logic [15:0] last_q;
    logic [21:0] cmd_addr;    // command latch, no address of its own
    logic [15:0] cmd_data;
    logic        edge_prot;
    int          cmd_cnt;
    int          n_bad;
    ////////////////////////////////////////////////////////////////////////
    // array read mode from power-up, nothing protected
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = {~8'(i), 8'(i)};
        cmd_cnt = 0;
        n_bad = 0;
        last_q = 16'h0000;
    end
    // edge sector flagged by a low pin, but the flag never blocks a program
    assign edge_prot = !i_protect_n && i_addr[7:4] == 4'h0;
    // array data for every address, no mode change modelled
    assign word = mem[i_addr[7:0]];
    // drive only while selected, gated and out of reset
    always_comb begin
        o_dq_oe = 16'h0000;
        o_dq    = ~last_q;    // released pins wander, never keep old data
        if (!i_ce_n && !i_oe_n && i_we_n && i_reset_n) begin
            o_dq_oe = i_byte_n ? 16'hFFFF : 16'h00FF;
            o_dq[7:0] = (!i_byte_n && i_dq[15]) ? word[15:8] : word[7:0];
            // undriven upper byte must not feed back through last_q
            o_dq[15:8] = i_byte_n ? word[15:8] : ~word[15:8];
        end
    end
    // remember what was last driven so released pins can differ from it
    always @(o_dq) begin
        if (|o_dq_oe) last_q = o_dq;
    end
    // one command cycle per strobe rise; reset aborts it
    always @(posedge i_we_n or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cmd_cnt = 0;
        end else if (i_ce_n === 1'b0) begin
            cmd_addr = i_addr;
            cmd_data = i_dq;
            cmd_cnt++;
            // second cycle of a pair programs under high voltage
            if (i_fast_prog_hv && (cmd_cnt % 2 == 0 || !edge_prot)) begin
                if (cmd_cnt % 2 == 0) mem[i_addr[7:0]] = i_dq;
            end
        end
    end
    // a strobe while outputs are gated or in reset is a host fault
    always @(negedge i_we_n) begin
        if (!i_oe_n || !i_reset_n) n_bad++;
    end
    // high voltage never rides on a read cycle
    always @(negedge i_oe_n) begin
        #1;
        if (i_fast_prog_hv) n_bad++;
    end
endmodule : fbd_flash_model
`default_nettype wire

/* dv/testbench.sv */
// self-checking bench for the flash bus controller and its apb registers
`default_nettype none
module testbench import fbd_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [7:0] ctl; logic [22:0] a; logic [15:0] e;} fbd_row_t;
    logic        mclk, arst_n, psel, penable, pwrite, pready, pslverr, er;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, st, rd;
    logic [21:0] f_addr;
    logic        ce_n, oe_n, we_n, f_rst_n, byte_n, hv, pr_out, pr_oe;
    logic [15:0] dq_c, dq_c_oe, dq_m, dq_m_oe, dq;
    logic        protect_n;
    int          n_mismatch, checks_done;
    int          n_clash = 0;
    fbd_row_t    rows [6] = '{'{8'h01, 23'h000000, 16'hFF00},
        '{8'h01, 23'h00003C, 16'hC33C}, '{8'h01, 23'h0000FF, 16'h00FF},
        '{8'h09, 23'h000079, 16'h00C3}, '{8'h09, 23'h000078, 16'h003C},
        '{8'h09, 23'h0001FE, 16'h00FF}};
    ////////////////////////////////////////////////////////////////////////
    // wire levels: controller wins where it drives, pull-up on protect
    assign dq = (dq_c & dq_c_oe) | (dq_m & ~dq_c_oe);
    assign protect_n = pr_oe ? pr_out : 1'b1;
    // both ends driving one data pin at once is a fault of either side
    always @(posedge mclk) begin
        if (|(dq_c_oe & dq_m_oe)) n_clash++;
    end
    fbd_ctrl fbd_ctrl_inst (.i_mclk(mclk), .i_arst_n(arst_n), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .o_addr(f_addr), .o_ce_n(ce_n), .o_oe_n(oe_n),
        .o_we_n(we_n), .o_reset_n(f_rst_n), .o_byte_n(byte_n), .i_dq_in(dq),
        .o_dq_out(dq_c), .o_dq_oe(dq_c_oe), .o_fast_prog_hv(hv),
        .o_protect_n_out(pr_out), .o_protect_n_oe(pr_oe));
    fbd_flash_model fbd_flash_model_inst (.i_addr(f_addr), .i_ce_n(ce_n),
        .i_oe_n(oe_n), .i_we_n(we_n), .i_reset_n(f_rst_n), .i_byte_n(byte_n),
        .i_dq(dq), .i_fast_prog_hv(hv), .i_protect_n(protect_n),
        .o_dq(dq_m), .o_dq_oe(dq_m_oe));
    // free-running 10 MHz clock
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    // a hang counts as a mismatch and ends the run the normal way
    initial begin
        repeat (20000) @(posedge mclk);
        n_mismatch++;
        summarize();
    end
    task automatic chk(input string nm, input logic [31:0] e, g);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // one apb transfer; answer taken at the edge that sees pready high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        logic ok;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            ok = (pready === 1'b1);
            q = prdata;
            e = pslverr;
        end while (!ok);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask : apb
    // start one flash operation, poll until it ends, fetch data, clear flags
    task automatic do_op(input logic [7:0] ctl, input logic [22:0] a,
                         input logic [15:0] wd);
        logic [31:0] x;
        int n;
        apb(1'b1, FBD_ADDR_OFS, {9'h000, a}, x, er);
        apb(1'b1, FBD_WDATA_OFS, {16'h0000, wd}, x, er);
        apb(1'b1, FBD_CTRL_OFS, {24'h000000, ctl}, x, er);
        n = 0;
        do begin
            apb(1'b0, FBD_STATUS_OFS, 32'h0, st, er);
            n++;
        end while (n < 60 && (st[0] !== 1'b0 || st[2:1] === 2'b00));
        chk("op ended", 32'h1, {31'h0, n < 60});
        apb(1'b0, FBD_RDATA_OFS, 32'h0, rd, er);
        apb(1'b1, FBD_STATUS_OFS, 32'h6, x, er);
    endtask : do_op
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize
    ////////////////////////////////////////////////////////////////////////
    // main sequence: reset, table of reads, then the awkward cases
    initial begin
        arst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        n_mismatch = 0;
        checks_done = 0;
        repeat (6) @(posedge mclk);
        chk("pins in reset", 32'h3F, {26'h0, ce_n, oe_n, we_n, f_rst_n, byte_n, ~hv});
        chk("dq drive in reset", 32'h0, {16'h0, dq_c_oe});
        arst_n <= 1'b1;
        @(posedge mclk);
        foreach (rows[i]) begin
            do_op(rows[i].ctl, rows[i].a, 16'h0000);
            chk("array read", {16'h0, rows[i].e}, rd);
            chk("read flags", 32'h2, st & 32'h7);
            chk("addr pins", {10'h0, rows[i].ctl[3] ? rows[i].a[22:1] : rows[i].a[21:0]}, {10'h0, f_addr});
            chk("upper pins float", 32'h0, {25'h0, dq_c_oe[14:8] & {7{~byte_n}}});
        end
        do_op(8'h41, 23'h000020, 16'h0);
        do_op(8'h01, 23'h000023, 16'h0);
        chk("page hit", 32'h1, {31'h0, st[FBD_ST_HIT]});
        chk("in-page data", 32'hDC23, rd);
        do_op(8'h41, 23'h000024, 16'h0);
        chk("select restarts", 32'h0, {31'h0, st[FBD_ST_HIT]});
        do_op(8'h03, 23'h000055, 16'h00AA);
        chk("latched addr", 32'h55, {10'h0, fbd_flash_model_inst.cmd_addr});
        chk("latched data", 32'hAA, {16'h0, fbd_flash_model_inst.cmd_data});
        do_op(8'h01, 23'h000055, 16'h0);
        chk("array kept", 32'hAA55, rd);
        do_op(8'h05, 23'h000000, 16'h0);
        chk("reset op done", 32'h2, st & 32'h7);
        chk("cycles aborted", 32'h0, fbd_flash_model_inst.cmd_cnt);
        do_op(8'h33, 23'h000005, 16'h0000);
        do_op(8'h33, 23'h000005, 16'h1234);
        chk("protect pin low", 32'h0, {31'h0, protect_n});
        do_op(8'h01, 23'h000005, 16'h0);
        chk("fast program", 32'h1234, rd);
        chk("protect pull-up", 32'h1, {31'h0, protect_n});
        do_op(8'h03, 23'h000006, 16'h0000);
        do_op(8'h03, 23'h000006, 16'h4321);
        do_op(8'h01, 23'h000006, 16'h0);
        chk("normal after hv", 32'hF906, rd);
        do_op(8'h11, 23'h000006, 16'h0);
        chk("read refused in hv", 32'h4, st & 32'h7);
        do_op(8'h07, 23'h000000, 16'h0);
        chk("bad op refused", 32'h4, st & 32'h7);
        for (int i = 0; i < 16; i++) begin
            do_op(8'h83, 23'(i), 16'(i));
            chk("buffer accepts", 32'h2, st & 32'h7);
        end
        do_op(8'h83, 23'h000010, 16'h0);
        chk("buffer full", 32'h4, st & 32'h7);
        chk("buffer count", {26'h0, FBD_BUF_WORDS}, {26'h0, st[13:8]});
        apb(1'b0, 8'h14, 32'h0, rd, er);
        chk("unmapped error", 32'h1, {31'h0, er});
        chk("unmapped data", 32'h0, rd);
        chk("host bus levels", 32'h0, fbd_flash_model_inst.n_bad);
        chk("bus contention", 32'h0, n_clash);
        summarize();
    end
endmodule : testbench
`default_nettype wire
